// ### verification/apmip_port_bench.sv
// bench: port roles, power sequencing and input serial port
`timescale 1ns/100ps
`default_nettype none
module apmip_port_bench;
	localparam logic [23:0] LW = 24'h9a5c3e; // left word sent
	localparam logic [23:0] RW = 24'h35c9a7; // right word sent
	logic sys_clk, rst, reg_wr, reg_rd; // clock, reset, strobes
	logic [7:0] reg_addr, attenuation; // address, attenuation
	logic [31:0] reg_wdata, reg_rdata, d; // bus data
	logic in_bit_clk_o, in_bit_clk_oe, in_word_clk_o, in_word_clk_oe;
	logic out_word_clk_o, out_word_clk_oe, out_bit_clk_o, out_bit_clk_oe;
	logic powered_up, ctrl_ready, out_rate_lower, decimation_active;
	logic sb, sw, sd, port_bit_clk, wck; // source lines, resolved pins
	apmip_pkg::apmip_sample_s in_sample, out_sample; // pairs
	logic [23:0] got_l, got_r, got_o, m; // captured words, mask
	int failures = 0, num_checks = 0, got_n = 0, k, n;
	logic owc = 1'b0; // slow far-side output word clock
	int owc_n = 0; // divider for that clock
	// rows: mode, in master, out master, half bit period
	logic [8:0] rows [8] = '{9'h000, 9'h051, 9'h094, 9'h0d2, 9'h100,
		9'h161, 9'h1a4, 9'h1e2};
	// formats: code in the top three bits, word width below
	logic [7:0] ftab [7] = '{8'h18, 8'h38, 8'h90, 8'hb2, 8'hd4,
		8'hf8, 8'h40};
	// pin level from whoever drives it
	assign port_bit_clk = in_bit_clk_oe ? in_bit_clk_o : sb;
	assign wck = in_word_clk_oe ? in_word_clk_o : sw;
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	apmip_port #(.INIT_DELAY_CYCLES(16)) apmip_port_inst (.sys_clk(sys_clk),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_bit_clk_i(port_bit_clk), .in_bit_clk_o(in_bit_clk_o),
		.in_bit_clk_oe(in_bit_clk_oe), .in_word_clk_i(wck),
		.in_word_clk_o(in_word_clk_o), .in_word_clk_oe(in_word_clk_oe),
		.serial_audio_in(sd), .out_word_clk_i(owc),
		.out_word_clk_o(out_word_clk_o), .out_word_clk_oe(out_word_clk_oe),
		.out_bit_clk_o(out_bit_clk_o), .out_bit_clk_oe(out_bit_clk_oe),
		.in_sample(in_sample), .out_sample(out_sample),
		.attenuation(attenuation), .powered_up(powered_up),
		.ctrl_ready(ctrl_ready), .out_rate_lower(out_rate_lower),
		.decimation_active(decimation_active));
	apmip_src_model apmip_src_model_inst (.sys_clk(sys_clk), .bit_clk(sb),
		.word_clk(sw), .data(sd));
	// capture each completed pair and each bypassed pair
	always @(posedge sys_clk) begin
		if (in_sample.valid === 1'b1) begin
			got_l <= in_sample.left;
			got_r <= in_sample.right;
			got_n <= got_n + 1;
		end
		if (out_sample.valid === 1'b1) got_o <= out_sample.left;
	end
	// output word clock of 600 cycles, slower than any input
	always @(posedge sys_clk) begin
		owc_n <= (owc_n == 299) ? 0 : owc_n + 1;
		if (owc_n == 299) begin
			owc <= ~owc;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask
	// level of the generated clock that sel picks
	function automatic logic pick(input int sel);
		return sel == 0 ? in_bit_clk_o : sel == 1 ? in_word_clk_o :
			sel == 2 ? out_bit_clk_o : out_word_clk_o;
	endfunction
	// length in cycles of one full half of a generated clock
	task automatic half_len(input int sel, output int len);
		logic v;
		v = pick(sel);
		len = 0;
		while (len < 600 && v === pick(sel)) begin
			@(negedge sys_clk);
			len++;
		end
		v = ~v;
		len = 0;
		while (len < 600 && v === pick(sel)) begin
			@(negedge sys_clk);
			len++;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog far beyond the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wr(apmip_pkg::REG_CTRL, 32'h1);
		for (int i = 0; i < 100 && ctrl_ready !== 1'b1; i++) @(posedge sys_clk);
		check(32'(ctrl_ready), 32'h1);
		rd(apmip_pkg::REG_CTRL, d);
		check(d, 32'h0);
		check(32'(powered_up), 32'h0);
		$display("test start-up done");
		foreach (rows[i]) begin
			wr(apmip_pkg::REG_CTRL, 32'h0);
			wr(apmip_pkg::REG_CTRL, {28'h0, rows[i][8:6], 1'b1});
			repeat (4) @(posedge sys_clk);
			check({in_bit_clk_oe, in_word_clk_oe, out_bit_clk_oe, out_word_clk_oe},
				{rows[i][5], rows[i][5], rows[i][4], rows[i][4]});
			rd(apmip_pkg::REG_STATUS, d);
			check(32'(d[3:1]), {29'h0, rows[i][4], rows[i][5], 1'b1});
			if (rows[i][5]) begin
				half_len(0, n);
				check(32'(n), 32'(rows[i][3:0]));
				half_len(1, n);
				check(32'(n), 32'(rows[i][3:0]) * 64);
				// both word clock periods measured by now
				repeat (1300) @(negedge sys_clk);
				check(32'(out_rate_lower), 32'h1);
			end
			if (rows[i][4]) begin
				half_len(2, n);
				check(32'(n), 32'(rows[i][3:0]));
				half_len(3, n);
				check(32'(n), 32'(rows[i][3:0]) * 64);
			end
		end
		$display("test port roles done");
		wr(apmip_pkg::REG_FMT, 32'h7);
		wr(apmip_pkg::REG_ATTEN, 32'hff);
		wr(apmip_pkg::REG_CTRL, 32'h0a);
		repeat (4) @(posedge sys_clk);
		check({30'h0, powered_up, in_bit_clk_oe}, 32'h0);
		check(32'(attenuation), 32'hff);
		rd(apmip_pkg::REG_FMT, d);
		check(d, 32'h7);
		rd(apmip_pkg::REG_CTRL, d);
		check(d, 32'h0a);
		$display("test power-down done");
		wr(apmip_pkg::REG_CTRL, 32'h11);
		repeat (4) @(posedge sys_clk);
		check(32'(decimation_active), 32'h1);
		foreach (ftab[i]) begin
			n = int'(ftab[i][4:0]);
			k = got_n;
			m = 24'hffffff << (24 - n);
			wr(apmip_pkg::REG_FMT, {29'h0, ftab[i][7:5]});
			apmip_src_model_inst.send(ftab[i][7:5], LW, RW);
			repeat (10) @(posedge sys_clk);
			// the lead-in half ends as a short right word: two pairs
			check(32'(got_n - k), (n == 0) ? 32'h0 : 32'h2);
			if (n != 0) begin
				check(32'(got_l), 32'(LW & m));
				check(32'(got_r), 32'(RW & m));
				check(32'(got_o), 32'(LW & m));
			end
		end
		$display("test input formats done");
		// second reset held for 25 cycles, 500 ns
		rst <= 1'b1;
		repeat (25) @(posedge sys_clk);
		rst <= 1'b0;
		rd(apmip_pkg::REG_CTRL, d);
		check(d, 32'h0);
		check({30'h0, powered_up, ctrl_ready}, 32'h0);
		$display("test second reset done");
		conclude();
	end
endmodule
`default_nettype wire

// ### verification/apmip_port_sva.sv
// checker: port roles, power sequencing and input port relations
`timescale 1ns/100ps
`default_nettype none
module apmip_chk #(
	parameter int INIT_DELAY_CYCLES = 16 // start-up wait
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // reset
	input wire logic in_bit_clk_oe, // in bit clock enable
	input wire logic in_word_clk_o, // in word clock drive
	input wire logic in_word_clk_oe, // in word clock enable
	input wire logic out_bit_clk_oe, // out bit clock enable
	input wire logic out_word_clk_oe, // out word clock enable
	input wire apmip_pkg::apmip_sample_s in_sample, // received pair
	input wire logic powered_up, // running
	input wire logic ctrl_ready, // writes open
	input wire logic out_rate_lower, // output slower
	input wire logic decimation_active // decimator on
);
	logic [15:0] age; // cycles since release
	logic [9:0] hc; // length of current half
	logic [9:0] hp; // length of previous half
	logic [1:0] hn; // halves seen while master
	logic wq; // word clock one cycle ago
	logic tg; // word clock changed
	assign tg = in_word_clk_o != wq;
	// measure word clock halves while the input port masters
	always_ff @(posedge sys_clk) begin
		wq <= in_word_clk_o;
		if (rst || !in_word_clk_oe) begin
			hc <= '0;
			hn <= '0;
		end else if (tg) begin
			hp <= hc;
			hc <= 10'h001;
			hn <= (hn == 2'h3) ? hn : hn + 2'h1;
		end else begin
			hc <= hc + 10'h001;
		end
	end
	// count cycles since reset release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			age <= '0;
		end else if (age != 16'hffff) begin
			age <= age + 16'h0001;
		end
	end
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_one_master: assert property (!(in_bit_clk_oe && out_bit_clk_oe))
		else $error("both ports drive clocks");
	a_reset_down: assert property (disable iff (1'b0) rst |=>
		!powered_up && !in_bit_clk_oe && !out_bit_clk_oe)
		else $error("not powered down in reset");
	a_reset_slave: assert property (disable iff (1'b0) rst |=>
		!in_word_clk_oe && !out_word_clk_oe)
		else $error("word clock driven after reset");
	a_down_idle: assert property ($fell(powered_up) |-> ##[0:1]
		!(in_bit_clk_oe || out_bit_clk_oe))
		else $error("master clock left running in power-down");
	a_pair_enable: assert property (in_word_clk_oe == in_bit_clk_oe &&
		out_word_clk_oe == out_bit_clk_oe)
		else $error("word and bit clock roles differ");
	a_even_halves: assert property (tg && hn >= 2'h2 |-> hc == hp)
		else $error("word clock duty not even");
	a_valid_pulse: assert property (in_sample.valid |=> !in_sample.valid)
		else $error("sample valid longer than one cycle");
	a_power_ready: assert property (powered_up |-> ctrl_ready)
		else $error("running before start-up wait");
	a_ready_early: assert property (age < INIT_DELAY_CYCLES |-> !ctrl_ready)
		else $error("writes opened too early");
	a_ready_late: assert property (age > INIT_DELAY_CYCLES + 2 |-> ctrl_ready)
		else $error("writes never opened");
	a_decim_low: assert property (out_rate_lower |-> decimation_active)
		else $error("decimator off with slower output");
endmodule
bind apmip_port apmip_chk #(.INIT_DELAY_CYCLES(INIT_DELAY_CYCLES)) apmip_chk_inst (
	.sys_clk(sys_clk),
	.rst(rst),
	.in_bit_clk_oe(in_bit_clk_oe),
	.in_word_clk_o(in_word_clk_o),
	.in_word_clk_oe(in_word_clk_oe),
	.out_bit_clk_oe(out_bit_clk_oe),
	.out_word_clk_oe(out_word_clk_oe),
	.in_sample(in_sample),
	.powered_up(powered_up),
	.ctrl_ready(ctrl_ready),
	.out_rate_lower(out_rate_lower),
	.decimation_active(decimation_active)
);
`default_nettype wire

// ### verification/apmip_src_model.sv
// partner: serial audio source feeding the input port as slave
`timescale 1ns/100ps
`default_nettype none
module apmip_src_model (
	input wire logic sys_clk, // pacing clock
	output var logic bit_clk, // bit clock to the port
	output var logic word_clk, // word clock to the port
	output var logic data // serial data to the port
);
	// idle levels; bit clock stands still outside frames
	initial begin
		bit_clk = 1'b0;
		word_clk = 1'b0;
		data = 1'b0;
	end
	// one bit clock per data bit
	task automatic put_bit(input logic wc, input logic d);
		word_clk <= wc;
		data <= d;
		repeat (3) @(posedge sys_clk);
		bit_clk <= 1'b1;
		repeat (3) @(posedge sys_clk);
		bit_clk <= 1'b0;
	endtask
	// one frame of 32 bits a half at 64 fs
	task automatic send(input logic [2:0] f, input logic [23:0] l,
		input logic [23:0] r);
		int n;
		int off;
		logic lv;
		logic [23:0] w;
		n = (!f[2] || f[1:0] == 2'b11) ? 24 : 16 + 2 * int'(f[1:0]);
		off = (f == 3'b001) ? 1 : (f[2] ? 32 - n : 0);
		lv = (f != 3'b001);
		put_bit(!lv, 1'b0);
		put_bit(!lv, 1'b1);
		for (int h = 0; h < 2; h++) begin
			w = (h == 0) ? l : r;
			for (int i = 0; i < 32; i++) begin
				put_bit(lv ^ (h == 1), (i >= off && i < off + n) ?
					w[23 - (i - off)] : 1'b0);
			end
		end
		put_bit(lv, 1'b0);
		put_bit(lv, 1'b0);
		// released line shows the inverse of its last bit
		data <= ~data;
	endtask
endmodule
`default_nettype wire

// ### verilog/apmip_pkg.sv
// package: constants, register map and carrier types of the port block
`default_nettype none
package apmip_pkg;
	// register byte offsets on the plain register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FMT = 8'h04;
	localparam logic [7:0] REG_ATTEN = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_IN_LEFT = 8'h10;
	localparam logic [7:0] REG_IN_RIGHT = 8'h14;
	localparam logic [7:0] REG_IN_PERIOD = 8'h18;
	localparam logic [7:0] REG_OUT_PERIOD = 8'h1c;
	// control register fields
	localparam int CTRL_PWR_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_BYPASS_BIT = 4;
	localparam int CTRL_DDS_BIT = 5;
	localparam int FMT_LSB = 0;
	localparam int ATTEN_LSB = 0;
	// status register fields
	localparam int STAT_INIT_DONE = 0;
	localparam int STAT_POWERED = 1;
	localparam int STAT_IN_MASTER = 2;
	localparam int STAT_OUT_MASTER = 3;
	localparam int STAT_RATE_READY = 4;
	localparam int STAT_OUT_LOWER = 5;
	localparam int STAT_DECIM = 6;
	localparam int STAT_FMT_BAD = 7;
	// timing
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int REF_MAX_HZ = 50_000_000;
	localparam int INIT_DELAY_US = 500;
	localparam int INIT_DELAY_CYC = (SYS_CLK_HZ / 1_000_000) * INIT_DELAY_US;
	localparam int INIT_CNT_W = 24;
	// audio framing
	localparam int SAMPLE_W = 24;
	localparam int RATE_W = 16;
	localparam int RATIO_SHIFT = 4; // 16:1 either way
	localparam logic [4:0] BCK_PER_HALF_LAST = 5'h1f; // 32 bit clocks
	localparam logic [5:0] BIT_IDX_MAX = 6'h3f;
	localparam logic [5:0] I2S_SKIP = 6'h01;
	// indices into the pin synchroniser vector
	localparam int PIN_BCK = 2;
	localparam int PIN_PORT_WORD_CLK = 1;
	localparam int PIN_DATA = 0;
	// port role codes
	typedef enum logic [2:0] {
		MODE_SLAVE_A = 3'b000,
		MODE_OUT_128 = 3'b001,
		MODE_OUT_512 = 3'b010,
		MODE_OUT_256 = 3'b011,
		MODE_SLAVE_B = 3'b100,
		MODE_IN_128 = 3'b101,
		MODE_IN_512 = 3'b110,
		MODE_IN_256 = 3'b111
	} apmip_mode_e;
	// input format codes
	typedef enum logic [2:0] {
		FMT_LJ24 = 3'b000,
		FMT_I2S24 = 3'b001,
		FMT_UNUSED2 = 3'b010,
		FMT_UNUSED3 = 3'b011,
		FMT_RJ16 = 3'b100,
		FMT_RJ18 = 3'b101,
		FMT_RJ20 = 3'b110,
		FMT_RJ24 = 3'b111
	} apmip_fmt_e;
	// power sequencing states
	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_DOWN = 2'b01,
		ST_RUN = 2'b10
	} apmip_state_e;
	// one stereo sample pair
	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
		logic valid;
	} apmip_sample_s;
	// complete state of the block
	typedef struct packed {
		apmip_state_e fsm;
		logic [INIT_CNT_W-1:0] init_cnt;
		logic pwr;
		apmip_mode_e mode;
		logic bypass;
		logic dds;
		apmip_fmt_e fmt;
		logic [7:0] atten;
		logic [2:0] in_s1;
		logic [2:0] in_s2;
		logic out_s1;
		logic out_s2;
		logic bck_prev;
		logic lr_last;
		logic in_lr_prev;
		logic out_lr_prev;
		logic [5:0] bit_idx;
		logic [SAMPLE_W-1:0] sr;
		logic [SAMPLE_W-1:0] acc;
		apmip_sample_s smp;
		logic [2:0] div;
		logic gen_bck;
		logic gen_port_word_clk;
		logic [4:0] gen_bits;
		logic [RATE_W-1:0] in_cnt;
		logic [RATE_W-1:0] in_period;
		logic [RATE_W-1:0] out_cnt;
		logic [RATE_W-1:0] out_period;
		logic [DATA_W-1:0] rdata;
	} apmip_state_s;
	localparam apmip_state_s STATE_RST = '0;
endpackage
`default_nettype wire

// ### verilog/apmip_port.sv
// port role control, power sequencing and input serial audio port
`timescale 1ns/100ps
`default_nettype none
module apmip_port #(
	parameter int INIT_DELAY_CYCLES = apmip_pkg::INIT_DELAY_CYC
) (
	input wire logic sys_clk, // reference clock, 50 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic in_bit_clk_i, // input bit clock pin level
	output logic in_bit_clk_o, // input bit clock drive
	output logic in_bit_clk_oe, // input bit clock enable
	input wire logic in_word_clk_i, // input word clock pin level
	output logic in_word_clk_o, // input word clock drive
	output logic in_word_clk_oe, // input word clock enable
	input wire logic serial_audio_in, // serial audio data pin
	input wire logic out_word_clk_i, // output word clock pin level
	output logic out_word_clk_o, // output word clock drive
	output logic out_word_clk_oe, // output word clock enable
	output logic out_bit_clk_o, // output bit clock drive
	output logic out_bit_clk_oe, // output bit clock enable
	output var apmip_pkg::apmip_sample_s in_sample, // received pair
	output var apmip_pkg::apmip_sample_s out_sample, // bypass pair
	output logic [7:0] attenuation, // half-dB attenuation steps
	output logic powered_up, // block running
	output logic ctrl_ready, // control writes accepted
	output logic out_rate_lower, // output rate below input rate
	output logic decimation_active // decimation filter selected
);
	// elaboration check on the wait count
	generate
		if (INIT_DELAY_CYCLES < 1 ||
			INIT_DELAY_CYCLES >= (1 << apmip_pkg::INIT_CNT_W)) begin : g_chk
			$error("INIT_DELAY_CYCLES out of range");
		end
	endgenerate

	localparam logic [apmip_pkg::INIT_CNT_W-1:0] INIT_LAST =
		apmip_pkg::INIT_CNT_W'(INIT_DELAY_CYCLES - 1);

	apmip_pkg::apmip_state_s q; // registered state
	apmip_pkg::apmip_state_s n; // next state
	logic run; // datapath active
	logic in_master; // input port drives its clocks
	logic out_master; // output port drives its clocks
	logic bck_rise; // input bit clock rising edge
	logic lr_now; // input word clock at that edge
	logic in_lr_rise; // input word clock rising edge
	logic out_lr_rise; // output word clock rising edge
	logic left_done; // finished word belongs to left channel
	logic fmt_bad; // reserved format programmed
	logic [apmip_pkg::SAMPLE_W-1:0] word; // finished word
	logic [apmip_pkg::RATE_W+3:0] in_scaled; // input period times 16
	logic [apmip_pkg::RATE_W+3:0] out_scaled; // output period times 16
	logic rate_ready; // both rates measured and in range

	// half bit-clock period in reference cycles for a role code
	function automatic logic [2:0] half_cycles(input logic [2:0] m);
		case (m[1:0])
			2'b01: half_cycles = 3'h1; // 128 fs -> bit clock ref/2
			2'b10: half_cycles = 3'h4; // 512 fs -> bit clock ref/8
			2'b11: half_cycles = 3'h2; // 256 fs -> bit clock ref/4
			default: half_cycles = 3'h1;
		endcase
	endfunction

	// role decode: which port is master
	// role code decode
	function automatic logic role_master(input logic [2:0] m,
		input logic inport);
		role_master = (m[1:0] != 2'b00) && (m[2] == inport);
	endfunction

	// right-justified word, left aligned into the sample width
	function automatic logic [apmip_pkg::SAMPLE_W-1:0] rj_word(
		input logic [apmip_pkg::SAMPLE_W-1:0] s, input logic [2:0] f);
		case (f)
			apmip_pkg::FMT_RJ16: rj_word = {s[15:0], 8'h00};
			apmip_pkg::FMT_RJ18: rj_word = {s[17:0], 6'h00};
			apmip_pkg::FMT_RJ20: rj_word = {s[19:0], 4'h0};
			default: rj_word = s;
		endcase
	endfunction

	// decoded roles and events
	always_comb begin
		run = (q.fsm == apmip_pkg::ST_RUN);
		in_master = run && role_master(q.mode, 1'b1);
		out_master = run && role_master(q.mode, 1'b0);
		bck_rise = q.in_s2[apmip_pkg::PIN_BCK] && !q.bck_prev;
		lr_now = q.in_s2[apmip_pkg::PIN_PORT_WORD_CLK];
		in_lr_rise = lr_now && !q.in_lr_prev;
		out_lr_rise = q.out_s2 && !q.out_lr_prev;
		fmt_bad = (q.fmt == apmip_pkg::FMT_UNUSED2) ||
			(q.fmt == apmip_pkg::FMT_UNUSED3);
		// I2S marks left with a low word clock
		left_done = (q.fmt == apmip_pkg::FMT_I2S24) ? !q.lr_last : q.lr_last;
		word = q.fmt[2] ? rj_word(q.sr, q.fmt) : q.acc;
		in_scaled = {q.in_period, 4'h0};
		out_scaled = {q.out_period, 4'h0};
		// both rates present and within 16:1 of each other
		rate_ready = (q.in_period != '0) && (q.out_period != '0) &&
			({4'h0, q.in_period} <= out_scaled) &&
			({4'h0, q.out_period} <= in_scaled);
	end

	// next-state logic
	always_comb begin
		n = q;
		n.rdata = '0;
		n.smp.valid = 1'b0;
		// pins through two flops; a master port feeds its own clocks
		n.in_s1[apmip_pkg::PIN_BCK] = in_master ? q.gen_bck : in_bit_clk_i;
		n.in_s1[apmip_pkg::PIN_PORT_WORD_CLK] = in_master ? q.gen_port_word_clk : in_word_clk_i;
		n.in_s1[apmip_pkg::PIN_DATA] = serial_audio_in;
		n.in_s2 = q.in_s1;
		n.out_s1 = out_master ? q.gen_port_word_clk : out_word_clk_i;
		n.out_s2 = q.out_s1;
		n.bck_prev = q.in_s2[apmip_pkg::PIN_BCK];
		n.in_lr_prev = lr_now;
		n.out_lr_prev = q.out_s2;

		// power sequencing
		case (q.fsm)
			apmip_pkg::ST_INIT: begin
				// internal start-up wait after reset release
				if (q.init_cnt == INIT_LAST) begin
					n.fsm = apmip_pkg::ST_DOWN;
				end else begin
					n.init_cnt = q.init_cnt + 1'b1;
				end
			end
			apmip_pkg::ST_DOWN: begin
				// leave power-down only when enable is set
				if (q.pwr) begin
					n.fsm = apmip_pkg::ST_RUN;
				end
			end
			apmip_pkg::ST_RUN: begin
				if (!q.pwr) begin
					n.fsm = apmip_pkg::ST_DOWN;
				end
			end
			default: begin
				n.fsm = apmip_pkg::ST_INIT;
			end
		endcase

		// register writes, refused during the start-up wait
		// writes ignored until the wait expires
		if (reg_wr && q.fsm != apmip_pkg::ST_INIT) begin
			case (reg_addr)
				apmip_pkg::REG_CTRL: begin
					n.pwr = reg_wdata[apmip_pkg::CTRL_PWR_BIT];
					n.mode = apmip_pkg::apmip_mode_e'(
						reg_wdata[apmip_pkg::CTRL_MODE_LSB +: 3]);
					n.bypass = reg_wdata[apmip_pkg::CTRL_BYPASS_BIT];
					n.dds = reg_wdata[apmip_pkg::CTRL_DDS_BIT];
				end
				apmip_pkg::REG_FMT: begin
					n.fmt = apmip_pkg::apmip_fmt_e'(
						reg_wdata[apmip_pkg::FMT_LSB +: 3]);
				end
				apmip_pkg::REG_ATTEN: begin
					// 256 steps of half a decibel
					n.atten = reg_wdata[apmip_pkg::ATTEN_LSB +: 8];
				end
				default: begin
					n.atten = q.atten;
				end
			endcase
		end

		// register reads, answered in the following cycle
		if (reg_rd) begin
			case (reg_addr)
				apmip_pkg::REG_CTRL: begin
					n.rdata[apmip_pkg::CTRL_PWR_BIT] = q.pwr;
					n.rdata[apmip_pkg::CTRL_MODE_LSB +: 3] = q.mode;
					n.rdata[apmip_pkg::CTRL_BYPASS_BIT] = q.bypass;
					n.rdata[apmip_pkg::CTRL_DDS_BIT] = q.dds;
				end
				apmip_pkg::REG_FMT: begin
					n.rdata[apmip_pkg::FMT_LSB +: 3] = q.fmt;
				end
				apmip_pkg::REG_ATTEN: begin
					n.rdata[apmip_pkg::ATTEN_LSB +: 8] = q.atten;
				end
				apmip_pkg::REG_STATUS: begin
					n.rdata[apmip_pkg::STAT_INIT_DONE] =
						(q.fsm != apmip_pkg::ST_INIT);
					n.rdata[apmip_pkg::STAT_POWERED] = run;
					n.rdata[apmip_pkg::STAT_IN_MASTER] = in_master;
					n.rdata[apmip_pkg::STAT_OUT_MASTER] = out_master;
					n.rdata[apmip_pkg::STAT_RATE_READY] = rate_ready;
					n.rdata[apmip_pkg::STAT_OUT_LOWER] =
						(q.out_period > q.in_period);
					n.rdata[apmip_pkg::STAT_DECIM] =
						(q.out_period > q.in_period) || !q.dds;
					n.rdata[apmip_pkg::STAT_FMT_BAD] = fmt_bad;
				end
				apmip_pkg::REG_IN_LEFT: begin
					n.rdata[apmip_pkg::SAMPLE_W-1:0] = q.smp.left;
				end
				apmip_pkg::REG_IN_RIGHT: begin
					n.rdata[apmip_pkg::SAMPLE_W-1:0] = q.smp.right;
				end
				apmip_pkg::REG_IN_PERIOD: begin
					n.rdata[apmip_pkg::RATE_W-1:0] = q.in_period;
				end
				apmip_pkg::REG_OUT_PERIOD: begin
					n.rdata[apmip_pkg::RATE_W-1:0] = q.out_period;
				end
				default: begin
					n.rdata = '0;
				end
			endcase
		end

		if (!run) begin
			// power-down: clocks, framing and estimator idle
			n.div = '0;
			n.gen_bck = 1'b0;
			n.gen_port_word_clk = 1'b0;
			n.gen_bits = '0;
			n.bit_idx = '0;
			n.in_cnt = '0;
			n.out_cnt = '0;
			n.in_period = '0;
			n.out_period = '0;
		end else begin
			// master clock generator, shared since only one port masters
			// bit clock at ref/(ratio/64) gives 64 fs
			if (in_master || out_master) begin
				if (q.div == half_cycles(q.mode) - 3'h1) begin
					n.div = '0;
					n.gen_bck = !q.gen_bck;
					// count bits on the falling edge
					if (q.gen_bck) begin
						n.gen_bits = q.gen_bits + 5'h01;
						// word clock toggles every 32 bits, 50% duty
						if (q.gen_bits == apmip_pkg::BCK_PER_HALF_LAST) begin
							n.gen_port_word_clk = !q.gen_port_word_clk;
						end
					end
				end else begin
					n.div = q.div + 3'h1;
				end
			end

			// word clock periods in reference cycles
			if (in_lr_rise) begin
				n.in_period = q.in_cnt;
				n.in_cnt = '0;
			end else if (q.in_cnt != '1) begin
				n.in_cnt = q.in_cnt + 1'b1;
			end
			if (out_lr_rise) begin
				n.out_period = q.out_cnt;
				n.out_cnt = '0;
			end else if (q.out_cnt != '1) begin
				n.out_cnt = q.out_cnt + 1'b1;
			end

			// serial capture on each input bit clock rising edge
			// one bit per bit clock, at any rate up to ref/2
			if (bck_rise) begin
				n.sr = {q.sr[apmip_pkg::SAMPLE_W-2:0],
					q.in_s2[apmip_pkg::PIN_DATA]};
				n.lr_last = lr_now;
				if (lr_now != q.lr_last) begin
					// word boundary: store the finished channel
					if (!fmt_bad) begin
						if (left_done) begin
							n.smp.left = word;
						end else begin
							n.smp.right = word;
							n.smp.valid = 1'b1;
						end
					end
					n.bit_idx = '0;
					n.acc = '0;
					// first bit of the new word, left-justified format only
					if (q.fmt == apmip_pkg::FMT_LJ24) begin
						n.acc[apmip_pkg::SAMPLE_W-1] =
							q.in_s2[apmip_pkg::PIN_DATA];
					end
				end else begin
					if (q.bit_idx != apmip_pkg::BIT_IDX_MAX) begin
						n.bit_idx = q.bit_idx + 6'h01;
					end
					// place MSB-first bits, at most 24 per word
					if (q.fmt == apmip_pkg::FMT_LJ24 &&
						q.bit_idx < 6'(apmip_pkg::SAMPLE_W - 1)) begin
						n.acc[5'(apmip_pkg::SAMPLE_W - 2) -
							q.bit_idx[4:0]] = q.in_s2[apmip_pkg::PIN_DATA];
					end
					// I2S skips the first bit after the word clock edge
					if (q.fmt == apmip_pkg::FMT_I2S24 &&
						q.bit_idx < 6'(apmip_pkg::SAMPLE_W) &&
						q.bit_idx + 6'h01 >= apmip_pkg::I2S_SKIP) begin
						n.acc[5'(apmip_pkg::SAMPLE_W - 1) -
							q.bit_idx[4:0]] = q.in_s2[apmip_pkg::PIN_DATA];
					end
				end
			end
		end
	end

	// state register
	// synchronous reset to all-zero state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= apmip_pkg::STATE_RST;
		end else begin
			q <= n;
		end
	end

	// outputs
	always_comb begin
		reg_rdata = q.rdata;
		// master pins drive, slave pins stay released
		in_bit_clk_o = q.gen_bck;
		in_word_clk_o = q.gen_port_word_clk;
		in_bit_clk_oe = in_master;
		in_word_clk_oe = in_master;
		out_bit_clk_o = q.gen_bck;
		out_word_clk_o = q.gen_port_word_clk;
		out_bit_clk_oe = out_master;
		out_word_clk_oe = out_master;
		in_sample = q.smp;
		// bypass hands input pairs to the output side
		out_sample = q.bypass ? q.smp : '0;
		attenuation = q.atten;
		powered_up = run;
		ctrl_ready = (q.fsm != apmip_pkg::ST_INIT);
		out_rate_lower = (q.out_period > q.in_period);
		// decimation forced when output is slower
		decimation_active = out_rate_lower || !q.dds;
	end
endmodule
`default_nettype wire
